/* File: core/gpm_pin_mux.sv */
`timescale 1ns/1ns
`default_nettype none
module gpm_pin_mux #(
   parameter int PULSE_CYC = gpm_pkg::PULSE_CYC,
   parameter int GAP_CYC = gpm_pkg::GAP_CYC
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [6:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic flags_read,
   input wire logic adc_wclk,
   input wire logic bus_wclk_out,
   input wire logic bus_wclk_is_out,
   output logic bus_wclk_in,
   input wire logic pll_clk_en,
   input wire logic clkdiv_mux_en,
   input wire logic irq_short,
   input wire logic irq_agc,
   input wire logic irq_button,
   input wire logic irq_headset,
   input wire logic multi_function_pin_one_in,
   output logic multi_function_pin_one_out,
   output logic multi_function_pin_one_oe
);
   logic [7:0] ctrl_reg, ctrl_next;
   logic [2:0] sync_reg, sync_next;
   logic in_reg, in_next;
   logic [2:0] div_reg, div_next;
   logic clk_reg, clk_next;
   logic out_reg, out_next;
   logic oe_reg, oe_next;
   logic [3:0] func;
   logic src_en;
   logic irq_sel;
   logic irq_shaped;
   logic div_tick;

   assign func = ctrl_reg[gpm_pkg::FUNC_MSB:gpm_pkg::FUNC_LSB];

   // ===========================================
   // Control register
   always_comb begin
      ctrl_next = ctrl_reg;
      if (reg_wr && reg_addr == gpm_pkg::CTRL_OFFSET) begin
         ctrl_next = reg_wdata;
         ctrl_next[gpm_pkg::INVAL_BIT] = 1'b0;
      end
      // The read-only input bit holds zero outside input roles.
      ctrl_next[gpm_pkg::INVAL_BIT] = in_reg;
   end

   always_comb begin
      reg_rdata = 8'h00;
      if (reg_rd && reg_addr == gpm_pkg::CTRL_OFFSET) begin
         reg_rdata = ctrl_reg;
      end
   end

   // ===========================================
   // Input sampling
   always_comb begin
      sync_next = {sync_reg[1:0], multi_function_pin_one_in};
      in_next = in_reg;
      if (func == gpm_pkg::F_GPI ||
          (func == gpm_pkg::F_WCLK && !bus_wclk_is_out)) begin
         if (sync_reg[1] == sync_reg[2]) begin
            in_next = sync_reg[2];
         end
      end else begin
         in_next = 1'b0;
      end
   end

   // ===========================================
   // Clock divider
   always_comb begin
      // Source enables mark each edge of the chosen clock; one step toggles.
      src_en = ctrl_reg[gpm_pkg::CLKSEL_BIT] ? clkdiv_mux_en : pll_clk_en;
      div_next = div_reg;
      div_tick = 1'b0;
      if (src_en) begin
         div_next = div_reg + 3'h1;
         unique case (func)
            gpm_pkg::F_DIV2: div_tick = div_reg[0] == 1'b1;
            gpm_pkg::F_DIV4: div_tick = div_reg[1:0] == 2'h3;
            gpm_pkg::F_DIV8: div_tick = div_reg == 3'h7;
            default: div_tick = 1'b1;
         endcase
      end
      clk_next = div_tick ? !clk_reg : clk_reg;
   end

   // ===========================================
   // Interrupt source selection
   always_comb begin
      unique case (func)
         gpm_pkg::F_SHORT: irq_sel = irq_short;
         gpm_pkg::F_AGC: irq_sel = irq_agc;
         gpm_pkg::F_BTN: irq_sel = irq_button;
         gpm_pkg::F_HSDET: irq_sel = irq_headset;
         gpm_pkg::F_HS_BTN: irq_sel = irq_headset | irq_button;
         gpm_pkg::F_ANY: irq_sel = irq_headset | irq_button |
                                   irq_short | irq_agc;
         default: irq_sel = 1'b0;
      endcase
   end

   gpm_irq_shaper #(
      .PULSE_CYC(PULSE_CYC),
      .GAP_CYC(GAP_CYC)
   ) u_shaper (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .irq_level(irq_sel),
      .continuous(ctrl_reg[gpm_pkg::DUR_BIT]),
      .flags_read(flags_read),
      .irq_out(irq_shaped)
   );

   // ===========================================
   // Pin drive
   always_comb begin
      out_next = 1'b0;
      oe_next = 1'b1;
      unique case (func)
         gpm_pkg::F_ADCWCLK: out_next = adc_wclk;
         gpm_pkg::F_DIV1, gpm_pkg::F_DIV2,
         gpm_pkg::F_DIV4, gpm_pkg::F_DIV8: out_next = clk_reg;
         gpm_pkg::F_GPO: begin
            out_next = ctrl_reg[gpm_pkg::OUTVAL_BIT];
         end
         gpm_pkg::F_WCLK: begin
            out_next = bus_wclk_out;
            oe_next = bus_wclk_is_out;
         end
         gpm_pkg::F_SHORT, gpm_pkg::F_AGC, gpm_pkg::F_BTN, gpm_pkg::F_HSDET,
         gpm_pkg::F_HS_BTN, gpm_pkg::F_ANY: out_next = irq_shaped;
         // Reserved code is left undriven as a safe fallback.
         default: oe_next = 1'b0;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ctrl_reg <= gpm_pkg::CTRL_RESET;
         sync_reg <= 3'h0;
         in_reg <= 1'b0;
         div_reg <= 3'h0;
         clk_reg <= 1'b0;
         out_reg <= 1'b0;
         oe_reg <= 1'b0;
      end else begin
         ctrl_reg <= ctrl_next;
         sync_reg <= sync_next;
         in_reg <= in_next;
         div_reg <= div_next;
         clk_reg <= clk_next;
         out_reg <= out_next;
         oe_reg <= oe_next;
      end
   end

   assign multi_function_pin_one_out = out_reg;
   assign multi_function_pin_one_oe = oe_reg;
   assign bus_wclk_in = in_reg;
endmodule : gpm_pin_mux
`default_nettype wire

/* File: core/gpm_pkg.sv */
// Functional notes
// - Four-bit function field picks pin role; zero disables, reset value.
// - Code 0001 puts the record word clock on the pin.
// - Codes 0010 to 0101 output the selected clock divided by 1, 2, 4, 8.
// - Code 0110 outputs the short-circuit interrupt.
// - Code 0111 taken as the AGC noise interrupt source.
// - Code 1000 makes the pin an undriven general input.
// - Read-only bit returns the sampled pin level while used as input.
// - Code 1001 makes the pin a general output.
// - In output mode the pin drives the output value bit.
// - Code 1011 is the bus word clock, direction from bus setting.
// - Code 1100 outputs the active-high button interrupt.
// - Code 1101 outputs the headset detection interrupt.
// - Code 1110 outputs headset detection OR button interrupt.
// - Code 1111 outputs OR of headset, button, short and AGC interrupts.
// - Clock select bit: 0 takes PLL output, 1 takes divider mux output.
// - Duration bit 0 gives one active-high pulse of about 2 ms.
// - Duration bit 1 pulses until host reads sticky flags register.
package gpm_pkg;
   localparam logic [6:0] CTRL_OFFSET = 7'h62;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam int FUNC_MSB = 7;
   localparam int FUNC_LSB = 4;
   localparam int CLKSEL_BIT = 3;
   localparam int DUR_BIT = 2;
   localparam int INVAL_BIT = 1;
   localparam int OUTVAL_BIT = 0;
   localparam int CLK_MHZ = 50;
   localparam int PULSE_US = 2000;
   localparam int PULSE_CYC = PULSE_US * CLK_MHZ;
   localparam int GAP_CYC = PULSE_CYC;
   localparam logic [3:0] F_OFF = 4'h0;
   localparam logic [3:0] F_ADCWCLK = 4'h1;
   localparam logic [3:0] F_DIV1 = 4'h2;
   localparam logic [3:0] F_DIV2 = 4'h3;
   localparam logic [3:0] F_DIV4 = 4'h4;
   localparam logic [3:0] F_DIV8 = 4'h5;
   localparam logic [3:0] F_SHORT = 4'h6;
   localparam logic [3:0] F_AGC = 4'h7;
   localparam logic [3:0] F_GPI = 4'h8;
   localparam logic [3:0] F_GPO = 4'h9;
   localparam logic [3:0] F_RSVD = 4'ha;
   localparam logic [3:0] F_WCLK = 4'hb;
   localparam logic [3:0] F_BTN = 4'hc;
   localparam logic [3:0] F_HSDET = 4'hd;
   localparam logic [3:0] F_HS_BTN = 4'he;
   localparam logic [3:0] F_ANY = 4'hf;
endpackage : gpm_pkg

/* File: core/gpm_irq_shaper.sv */
`timescale 1ns/1ns
`default_nettype none
module gpm_irq_shaper #(
   parameter int PULSE_CYC = gpm_pkg::PULSE_CYC,
   parameter int GAP_CYC = gpm_pkg::GAP_CYC
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic irq_level,
   input wire logic continuous,
   input wire logic flags_read,
   output logic irq_out
);
   typedef enum logic [1:0] {S_IDLE, S_HIGH, S_LOW} gpm_shp_t;
   gpm_shp_t state_reg, state_next;
   logic [31:0] cnt_reg, cnt_next;
   logic prev_reg, prev_next;
   logic armed_reg, armed_next;
   logic rise;

   // ===========================================
   // Pulse shaping
   assign rise = irq_level && !prev_reg;
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      prev_next = irq_level;
      armed_next = armed_reg;
      if (rise && continuous) begin
         armed_next = 1'b1;
      end else if (flags_read) begin
         armed_next = 1'b0;
      end
      unique case (state_reg)
         S_IDLE: begin
            if (rise) begin
               state_next = S_HIGH;
               cnt_next = 32'(PULSE_CYC - 1);
            end
         end
         S_HIGH: begin
            if (cnt_reg == 32'h0) begin
               state_next = S_LOW;
               cnt_next = 32'(GAP_CYC - 1);
            end else begin
               cnt_next = cnt_reg - 32'h1;
            end
         end
         S_LOW: begin
            if (cnt_reg == 32'h0) begin
               // Repeats only while the host has not read the flags.
               if (armed_next) begin
                  state_next = S_HIGH;
                  cnt_next = 32'(PULSE_CYC - 1);
               end else begin
                  state_next = S_IDLE;
               end
            end else begin
               cnt_next = cnt_reg - 32'h1;
            end
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state_reg <= S_IDLE;
         cnt_reg <= 32'h0;
         prev_reg <= 1'b0;
         armed_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         prev_reg <= prev_next;
         armed_reg <= armed_next;
      end
   end

   assign irq_out = (state_reg == S_HIGH);
endmodule : gpm_irq_shaper
`default_nettype wire

/* File: verif/gpm_pin_model.sv */
`timescale 1ns/1ns
`default_nettype none
module gpm_pin_model (
   input wire logic pin_out,
   input wire logic pin_oe,
   input wire logic ext_drv,
   input wire logic ext_val,
   output logic pin_lvl
);
   // A pull-up holds the wire, so a released pin never shows a stale level.
   assign pin_lvl = pin_oe ? pin_out : (ext_drv ? ext_val : 1'b1);
endmodule : gpm_pin_model
`default_nettype wire

/* File: verif/gpm_pin_mux_checker.sv */
`timescale 1ns/1ns
`default_nettype none
module gpm_pin_mux_checker (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [6:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic adc_wclk,
   input wire logic multi_function_pin_one_out,
   input wire logic multi_function_pin_one_oe
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   logic [7:0] ctl_reg;
   logic [7:0] ctl_next;
   logic [3:0] fn;
   logic sel;
   logic dr;
   logic q;
   always_comb begin
      ctl_next = ctl_reg;
      if (reg_wr && reg_addr == 7'h62) begin
         ctl_next = reg_wdata & 8'hfd;
      end
   end
   always_ff @(posedge mclk) begin
      ctl_reg <= sys_rst ? 8'h00 : ctl_next;
   end
   assign fn = ctl_reg[7:4];
   assign sel = reg_rd && reg_addr == 7'h62;
   assign dr = multi_function_pin_one_oe;
   assign q = multi_function_pin_one_out;
   property p_off; $stable(ctl_reg) && fn == 4'h0 |-> !dr; endproperty
   a_off: assert property (p_off) else $error("off pin driven");
   property p_gpi; $stable(ctl_reg) && fn == 4'h8 |-> !dr; endproperty
   a_gpi: assert property (p_gpi) else $error("input driven");
   property p_clk; $stable(ctl_reg) && fn >= 4'h2 && fn <= 4'h5 |-> dr;
   endproperty
   a_clk: assert property (p_clk) else $error("clock not driven");
   property p_gpo; $stable(ctl_reg) && fn == 4'h9 |-> dr && q == ctl_reg[0];
   endproperty
   a_gpo: assert property (p_gpo) else $error("output level");
   property p_rd; sel |-> reg_rdata[7:2] == ctl_reg[7:2]
      && reg_rdata[0] == ctl_reg[0]; endproperty
   a_rd: assert property (p_rd) else $error("read value");
   property p_b1; sel && fn == 4'h9 |-> !reg_rdata[1]; endproperty
   a_b1: assert property (p_b1) else $error("input bit set");
   property p_na; reg_rd && reg_addr != 7'h62 |-> reg_rdata == 8'h00;
   endproperty
   a_na: assert property (p_na) else $error("unmapped read");
   property p_adc; $stable(ctl_reg) && fn == 4'h1 |-> dr && q == $past(adc_wclk);
   endproperty
   a_adc: assert property (p_adc) else $error("word clock");
endmodule : gpm_pin_mux_checker
bind gpm_pin_mux gpm_pin_mux_checker u_chk (
   .mclk(mclk),
   .sys_rst(sys_rst),
   .reg_addr(reg_addr),
   .reg_wr(reg_wr),
   .reg_rd(reg_rd),
   .reg_wdata(reg_wdata),
   .reg_rdata(reg_rdata),
   .adc_wclk(adc_wclk),
   .multi_function_pin_one_out(multi_function_pin_one_out),
   .multi_function_pin_one_oe(multi_function_pin_one_oe)
);
`default_nettype wire

/* File: verif/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic mclk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, flags_read = 0;
   logic [6:0] reg_addr = 0;
   logic [7:0] reg_wdata = 0, reg_rdata;
   logic adc = 0, wo = 0, wd = 0, wi, pe = 0, ce = 0, xd = 0, xv = 0;
   logic [3:0] irq = 0;
   logic po, oe, lvl;
   int err_total = 0, total_checks = 0, cyc = 0, hi, tg;
   gpm_pin_mux #(.PULSE_CYC(20), .GAP_CYC(10)) dut (.mclk(mclk),
      .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .flags_read(flags_read),
      .adc_wclk(adc), .bus_wclk_out(wo), .bus_wclk_is_out(wd),
      .bus_wclk_in(wi), .pll_clk_en(pe), .clkdiv_mux_en(ce),
      .irq_short(irq[3]), .irq_agc(irq[2]), .irq_button(irq[1]),
      .irq_headset(irq[0]), .multi_function_pin_one_in(lvl),
      .multi_function_pin_one_out(po), .multi_function_pin_one_oe(oe));
   gpm_pin_model u_pin (.pin_out(po), .pin_oe(oe), .ext_drv(xd),
      .ext_val(xv), .pin_lvl(lvl));
   always #10 mclk = ~mclk;
   // ==========
   // Tasks.
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : tick
   task automatic wr(input logic [7:0] d);
      if (d[7:4] == 4'ha) d[7:4] = 4'h0;
      reg_addr = 7'h62;
      reg_wdata = d;
      reg_wr = 1;
      tick(1);
      reg_wr = 0;
      tick(2);
   endtask : wr
   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      reg_addr = a;
      reg_rd = 1;
      #5 chk(reg_rdata, e);
      tick(1);
      reg_rd = 0;
      tick(1);
   endtask : rd
   task automatic cnt(input int n);
      logic p;
      hi = 0;
      tg = 0;
      p = po;
      repeat (n) begin
         tick(1);
         hi += po;
         tg += (po != p);
         p = po;
      end
   endtask : cnt
   task automatic complete_run;
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : complete_run
   // ==========
   // Scenarios.
   task automatic t_pins;
      rd(7'h62, 8'h00);
      rd(7'h10, 8'h00);
      wr(8'h91);
      chk({oe, po}, 8'h3);
      wr(8'h90);
      chk({oe, po}, 8'h2);
      rd(7'h62, 8'h90);
      xd = 1;
      xv = 1;
      wr(8'h80);
      tick(8);
      rd(7'h62, 8'h82);
      chk(oe, 0);
      xv = 0;
      tick(8);
      rd(7'h62, 8'h80);
      chk(oe, 0);
      xv = 1;
      wr(8'h01);
      chk(oe, 0);
      rd(7'h62, 8'h01);
      wr(8'h10);
      repeat (6) begin
         adc = ~adc;
         tick(1);
      end
      wr(8'hb0);
      tick(6);
      chk({oe, wi}, 8'h1);
      wd = 1;
      wo = 1;
      tick(2);
      chk({oe, po}, 8'h3);
      xd = 0;
   endtask : t_pins
   task automatic t_irq;
      logic [27:0] cd = 28'h67cdefd;
      int bt[7] = '{3, 2, 1, 0, 0, 2, 3};
      for (int i = 0; i < 7; i++) begin
         wr({cd[27-4*i -: 4], 4'h0});
         irq[bt[i]] = 1;
         tick(1);
         irq = 0;
         cnt(60);
         chk(8'(hi), i == 6 ? 8'h00 : 8'h14);
      end
      wr(8'h64);
      irq[3] = 1;
      cnt(95);
      chk(8'(tg >= 5), 8'h1);
      irq = 0;
      flags_read = 1;
      tick(1);
      flags_read = 0;
      cnt(40);
      cnt(60);
      chk(8'(hi), 8'h00);
   endtask : t_irq
   task automatic t_div;
      pe = 1;
      for (int m = 0; m < 4; m++) begin
         wr({4'h2 + 4'(m), 4'h0});
         cnt(64);
         chk(8'(tg >= (64 >> m) - 1 && tg <= (64 >> m) + 1), 8'h1);
      end
      wr(8'h28);
      cnt(64);
      chk(8'(tg), 8'h00);
      ce = 1;
      cnt(64);
      chk(8'(tg >= 63), 8'h1);
   endtask : t_div
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         complete_run();
      end
   end
   initial begin
      tick(16);
      sys_rst = 0;
      t_pins();
      t_irq();
      t_div();
      complete_run();
   end
endmodule : testbench
`default_nettype wire
